// File: logic/nvac_consts.svh
// Register offsets, field positions, reset values and timing constants of the access controller.
`ifndef NVAC_CONSTS_SVH
`define NVAC_CONSTS_SVH

// ************************************************************
// Register offsets (3-bit register port address)
// ************************************************************
`define NVAC_OFS_DATA_LOW   3'h0
`define NVAC_OFS_ADDR_LOW   3'h1
`define NVAC_OFS_DATA_HIGH  3'h2
`define NVAC_OFS_ADDR_HIGH  3'h3
`define NVAC_OFS_CONTROL    3'h4
`define NVAC_OFS_UNLOCK     3'h5

// ************************************************************
// Control register field positions
// ************************************************************
`define NVAC_BIT_SPACE      7
`define NVAC_BIT_ABORT      3
`define NVAC_BIT_ALLOW      2
`define NVAC_BIT_WSTART     1
`define NVAC_BIT_RSTART     0

// ************************************************************
// Reset values, unlock keys and timing
// ************************************************************
`define NVAC_RST_BYTE       8'h00
`define NVAC_KEY_FIRST      8'h55
`define NVAC_KEY_SECOND     8'hAA
`define NVAC_DATA_HIGH_MASK 8'h3F
`define NVAC_ADDR_HIGH_MASK 8'h0F
`define NVAC_PWRUP_MS       64
`define NVAC_CLK_KHZ        25000
`define NVAC_WRITE_CYCLES   32'd100000

`endif

// File: logic/nvac_pkg.sv
// Types shared by the nonvolatile access controller.
package nvac_pkg;

    // Register port request from the core.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } nvac_req_t;

    // Write engine states.
    typedef enum logic [1:0] {
        NVAC_IDLE  = 2'b00,
        NVAC_ERASE = 2'b01,
        NVAC_PROG  = 2'b10
    } nvac_wstate_t;

    // Unlock sequence progress.
    typedef enum logic [1:0] {
        NVAC_LOCKED = 2'b00,
        NVAC_KEY1   = 2'b01,
        NVAC_KEY2   = 2'b10
    } nvac_unlock_t;

    // Program read pipeline states.
    typedef enum logic [1:0] {
        NVAC_PR_IDLE  = 2'b00,
        NVAC_PR_WAIT  = 2'b01,
        NVAC_PR_FETCH = 2'b10
    } nvac_pread_t;

endpackage

// File: logic/nvac_data_mem.sv
// Byte-wide data array model with registered read data and erase-then-program writes.
`timescale 1ns/10ps
module nvac_data_mem
    import nvac_pkg::*;
#(
    parameter int AW = 8
) (
    // Clock.
    input  wire logic          sys_clk,
    // Access.
    input  wire logic [AW-1:0] addr,
    input  wire logic          erase,
    input  wire logic          prog,
    input  wire logic [7:0]    wdata,
    output logic [7:0]         rdata
);
    `include "nvac_consts.svh"

    logic [7:0] mem [0:(1<<AW)-1];

    // Erase leaves the cell all ones, programming stores the byte; read is registered.
    always_ff @(posedge sys_clk) begin
        if (erase) begin
            mem[addr] <= 8'hFF;
        end else if (prog) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule

// File: logic/nvac_ctrl.sv
// Register-driven controller for data EEPROM byte access and program flash word reads.
//
// Strobed register access and the address map were left to the implementer.
`timescale 1ns/10ps
`include "nvac_consts.svh"
module nvac_ctrl
    import nvac_pkg::*;
#(
    parameter int DATA_AW       = 8,
    parameter int PROG_AW       = 12,
    parameter int WRITE_CYCLES  = `NVAC_WRITE_CYCLES,
    parameter int PWRUP_CYCLES  = `NVAC_PWRUP_MS * `NVAC_CLK_KHZ
) (
    // Clock and reset.
    input  wire logic         sys_clk,
    input  wire logic         srst,
    // Cause of the last reset, valid while srst is high.
    input  wire logic         power_on_reset,
    input  wire logic         external_master_reset,
    input  wire logic         watchdog_timer,
    input  wire logic         brownout_reset,
    // Register port.
    input  wire nvac_req_t    req,
    output logic [7:0]        rdata,
    // Program flash read port (word must stand while the strobe is high).
    output logic              prog_rd_reg,
    output logic [11:0]       prog_addr_reg,
    input  wire logic [13:0]  prog_word,
    // Core stall: the instruction in this cycle must be ignored.
    output logic              core_skip_reg,
    // Write-complete event to the interrupt flag register outside.
    output logic              write_done_flag
);

    // ************************************************************
    // Registers
    // ************************************************************
    logic [7:0]   data_low_reg;
    logic [7:0]   addr_low_reg;
    logic [5:0]   data_high_reg;
    logic [3:0]   addr_high_reg;
    logic         space_select_reg;
    logic         write_abort_flag_reg;
    logic         write_allow_reg;
    logic         wstart_reg;
    logic         rstart_reg;
    logic         done_reg;
    nvac_unlock_t unlock_reg;
    nvac_wstate_t wstate_reg;
    nvac_pread_t  pread_reg;
    // Counters are 32 bits so any parameter value fits.
    logic [31:0]  wcount_reg;
    logic [31:0]  pwrup_reg;
    logic         pwrup_busy_reg;
    logic         drd_reg;
    logic [7:0]   mem_rdata;
    logic         mem_erase;
    logic         mem_prog;

    // Decoded strobes.
    logic wr_ctl;
    logic wr_unlock;
    logic set_wstart;
    logic write_go;
    logic set_rstart;
    logic wr_done_now;

    // Decodes include the strobe, so an idle bus never matches.
    assign wr_ctl    = req.wr && (req.addr == `NVAC_OFS_CONTROL);
    assign wr_unlock = req.wr && (req.addr == `NVAC_OFS_UNLOCK);
    // Write start needs allow already set, data space, idle engine.
    assign set_wstart = wr_ctl && req.wdata[`NVAC_BIT_WSTART] && write_allow_reg
                        && !req.wdata[`NVAC_BIT_SPACE] && !space_select_reg && !wstart_reg;
    // A write really starts only after both keys and outside the power-up window.
    assign write_go   = set_wstart && (unlock_reg == NVAC_KEY2) && !pwrup_busy_reg;
    // A start that finds a read pending is dropped, so it cannot
    // restart the pipeline halfway.
    assign set_rstart = wr_ctl && req.wdata[`NVAC_BIT_RSTART] && !rstart_reg;
    // The last count, the program pulse and the flag share one edge.
    assign wr_done_now = (wstate_reg == NVAC_PROG) && (wcount_reg == 32'h0);

    // ************************************************************
    // Power-up timer
    // ************************************************************
    // Only a power-on reset restarts the timer; other resets leave it alone.
    // A pin or watchdog reset must not reopen the blocked window.
    always_ff @(posedge sys_clk) begin
        if (srst && power_on_reset) begin
            pwrup_reg      <= 32'(PWRUP_CYCLES);
            pwrup_busy_reg <= 1'b1;
        end else if (pwrup_reg != 32'h0) begin
            pwrup_reg      <= pwrup_reg - 32'h1;
        end else begin
            pwrup_busy_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Unlock sequence tracker
    // ************************************************************
    // Any register access other than the expected next step rearms the lock.
    // Keys count only on the unlock port; a stray 55h elsewhere arms nothing.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            unlock_reg <= NVAC_LOCKED;
        end else if (wr_unlock && req.wdata == `NVAC_KEY_FIRST) begin
            unlock_reg <= NVAC_KEY1;
        end else if (wr_unlock && req.wdata == `NVAC_KEY_SECOND && unlock_reg == NVAC_KEY1) begin
            unlock_reg <= NVAC_KEY2;
        end else if (req.wr || req.rd) begin
            unlock_reg <= NVAC_LOCKED;
        end
    end

    // ************************************************************
    // Control register
    // ************************************************************
    // Abort flag survives all but a power-on reset so software can see a cut write afterwards.
    // Write allow is cleared by software or reset, never by the engine.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            space_select_reg <= 1'b0;
            wstart_reg       <= 1'b0;
            rstart_reg       <= 1'b0;
            if (power_on_reset) begin
                write_allow_reg      <= 1'b0;
                write_abort_flag_reg <= 1'b0;
            end else begin
                write_allow_reg <= 1'b0;
                if (wstate_reg != NVAC_IDLE && (external_master_reset || watchdog_timer
                                                || brownout_reset)) begin
                    write_abort_flag_reg <= 1'b1;
                end
            end
        end else begin
            if (wr_ctl) begin
                space_select_reg     <= req.wdata[`NVAC_BIT_SPACE];
                write_allow_reg      <= req.wdata[`NVAC_BIT_ALLOW];
                write_abort_flag_reg <= req.wdata[`NVAC_BIT_ABORT];
            end
            // Start bits: software may set, only hardware clears.
            if (write_go) begin
                wstart_reg <= 1'b1;
            end else if (wr_done_now) begin
                wstart_reg <= 1'b0;
            end
            if (set_rstart) begin
                rstart_reg <= 1'b1;
            end else if (drd_reg || pread_reg == NVAC_PR_FETCH) begin
                rstart_reg <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Write engine: erase then program, timed by a counter
    // ************************************************************
    // Out of idle the engine watches only its counter; only a reset
    // can cut the write short; the abort flag records a pin, watchdog or brownout cut, and a power-on reset clears it.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wstate_reg <= NVAC_IDLE;
            wcount_reg <= 32'h0;
            done_reg   <= 1'b0;
        end else begin
            done_reg <= wr_done_now;
            case (wstate_reg)
                NVAC_IDLE: begin
                    if (write_go) begin
                        wstate_reg <= NVAC_ERASE;
                    end
                end
                NVAC_ERASE: begin
                    wstate_reg <= NVAC_PROG;
                    wcount_reg <= 32'(WRITE_CYCLES);
                end
                NVAC_PROG: begin
                    // Write allow is not looked at here, so clearing it cannot stop us.
                    if (wcount_reg == 32'h0) begin
                        wstate_reg <= NVAC_IDLE;
                    end else begin
                        wcount_reg <= wcount_reg - 32'h1;
                    end
                end
                default: begin
                    wstate_reg <= NVAC_IDLE;
                end
            endcase
        end
    end

    // Array strobes decode registered state, so they cannot glitch.
    assign mem_erase = (wstate_reg == NVAC_ERASE);
    assign mem_prog  = wr_done_now;
    assign write_done_flag = done_reg;

    // ************************************************************
    // Data array
    // ************************************************************
    // Only the low address byte reaches the array.
    nvac_data_mem #(
        .AW (DATA_AW)
    ) u_mem (
        .sys_clk (sys_clk),
        .addr    (addr_low_reg),
        .erase   (mem_erase),
        .prog    (mem_prog),
        .wdata   (data_low_reg),
        .rdata   (mem_rdata)
    );

    // ************************************************************
    // Read engines
    // ************************************************************
    // Data read: the array is registered, so the byte is captured one cycle on.
    // Space comes from the written value, so one control write can
    // both point at a memory and start the read.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            drd_reg <= 1'b0;
        end else begin
            drd_reg <= set_rstart && !req.wdata[`NVAC_BIT_SPACE];
        end
    end

    // Program read: wait one cycle, fetch in the second and skip that instruction.
    // The flash answers while the strobe stands; the word is taken at its end.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pread_reg     <= NVAC_PR_IDLE;
            prog_rd_reg   <= 1'b0;
            core_skip_reg <= 1'b0;
            prog_addr_reg <= 12'h000;
        end else begin
            prog_rd_reg   <= 1'b0;
            core_skip_reg <= 1'b0;
            case (pread_reg)
                NVAC_PR_IDLE: begin
                    if (set_rstart && req.wdata[`NVAC_BIT_SPACE]) begin
                        pread_reg <= NVAC_PR_WAIT;
                    end
                end
                NVAC_PR_WAIT: begin
                    pread_reg     <= NVAC_PR_FETCH;
                    prog_rd_reg   <= 1'b1;
                    core_skip_reg <= 1'b1;
                    prog_addr_reg <= {addr_high_reg, addr_low_reg};
                end
                NVAC_PR_FETCH: begin
                    pread_reg <= NVAC_PR_IDLE;
                end
                default: begin
                    pread_reg <= NVAC_PR_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // Data and address registers
    // ************************************************************
    // A read result wins over a software write landing in the same cycle.
    // The losing write is dropped, so software must not write the data
    // registers while its own read is in flight.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            data_low_reg  <= `NVAC_RST_BYTE;
            data_high_reg <= 6'h00;
        end else if (drd_reg) begin
            data_low_reg <= mem_rdata;
        end else if (pread_reg == NVAC_PR_FETCH) begin
            data_low_reg  <= prog_word[7:0];
            data_high_reg <= prog_word[13:8];
        end else if (req.wr && req.addr == `NVAC_OFS_DATA_LOW) begin
            data_low_reg <= req.wdata;
        end else if (req.wr && req.addr == `NVAC_OFS_DATA_HIGH) begin
            data_high_reg <= req.wdata[5:0];
        end
    end

    // Address registers; the high one keeps only the flash bits.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            addr_low_reg  <= `NVAC_RST_BYTE;
            addr_high_reg <= 4'h0;
        end else if (req.wr && req.addr == `NVAC_OFS_ADDR_LOW) begin
            addr_low_reg <= req.wdata;
        end else if (req.wr && req.addr == `NVAC_OFS_ADDR_HIGH) begin
            addr_high_reg <= req.wdata[3:0];
        end
    end

    // ************************************************************
    // Read data path
    // ************************************************************
    // Unlock port and unmapped offsets return zero; unimplemented bits read zero.
    // Reads have no side effect here; only the unlock tracker sees them.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata <= `NVAC_RST_BYTE;
        end else if (!req.rd) begin
            rdata <= `NVAC_RST_BYTE;
        end else if (req.addr == `NVAC_OFS_DATA_LOW) begin
            rdata <= data_low_reg;
        end else if (req.addr == `NVAC_OFS_ADDR_LOW) begin
            rdata <= addr_low_reg;
        end else if (req.addr == `NVAC_OFS_DATA_HIGH) begin
            rdata <= {2'b00, data_high_reg};
        end else if (req.addr == `NVAC_OFS_ADDR_HIGH) begin
            rdata <= {4'h0, addr_high_reg};
        end else if (req.addr == `NVAC_OFS_CONTROL) begin
            rdata <= {space_select_reg, 3'b000, write_abort_flag_reg,
                      write_allow_reg, wstart_reg, rstart_reg};
        end else begin
            rdata <= `NVAC_RST_BYTE;
        end
    end

endmodule

// File: test/nvac_flash_model.sv
// Program flash model for the far side of the access controller.
`timescale 1ns/10ps
module nvac_flash_model (
    // Clock.
    input  wire logic        sys_clk,
    // Word read port.
    input  wire logic        prog_rd_reg,
    input  wire logic [11:0] prog_addr_reg,
    output logic      [13:0] prog_word
);
    // ************************************************************
    // Word answer
    // ************************************************************
    // The word stands only while the strobe is high.
    // Otherwise it toggles every cycle, so a late capture is caught.
    logic [13:0] junk_reg = 14'h0000;
    always @(posedge sys_clk) junk_reg <= ~junk_reg;
    assign prog_word = prog_rd_reg ? {2'b10, prog_addr_reg ^ 12'h3C5} : junk_reg;
endmodule

// File: test/nvac_ctrl_checker.sv
// Port assertions for the access controller, bound to its top module.
`timescale 1ns/10ps
`include "nvac_consts.svh"
module nvac_ctrl_checker
    import nvac_pkg::*;
#(
    parameter int WRITE_CYCLES = 100000,
    parameter int PWRUP_CYCLES = 1600000
) (
    // Clock, reset and reset causes.
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        power_on_reset,
    input wire logic        external_master_reset,
    input wire logic        watchdog_timer,
    input wire logic        brownout_reset,
    // Register port.
    input wire nvac_req_t   req,
    input wire logic [7:0]  rdata,
    // Flash port, core stall and completion.
    input wire logic        prog_rd_reg,
    input wire logic [11:0] prog_addr_reg,
    input wire logic [13:0] prog_word,
    input wire logic        core_skip_reg,
    input wire logic        write_done_flag
);
    // ************************************************************
    // Unlock tracking
    // ************************************************************
    logic [1:0] key_reg;
    logic       armed_reg;
    wire        ctl_wr = req.wr && (req.addr == `NVAC_OFS_CONTROL);
    wire        key_wr = req.wr && (req.addr == `NVAC_OFS_UNLOCK);

    // Any access other than the next key drops the sequence.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            key_reg <= 2'h0;
        end else if (key_wr && req.wdata == `NVAC_KEY_FIRST) begin
            key_reg <= 2'h1;
        end else if (key_wr && req.wdata == `NVAC_KEY_SECOND && key_reg == 2'h1) begin
            key_reg <= 2'h2;
        end else if (req.wr || req.rd) begin
            key_reg <= 2'h0;
        end
    end

    // A legal start arms the completion check; a reset kills the write.
    always_ff @(posedge sys_clk) begin
        if (srst || write_done_flag) begin
            armed_reg <= 1'b0;
        end else if (key_reg == 2'h2 && ctl_wr && req.wdata[1] && !req.wdata[7]) begin
            armed_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);

    property p_rdata_idle;
        !$past(req.rd) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read");
    property p_unlock_zero;
        req.rd && req.addr >= `NVAC_OFS_UNLOCK |=> rdata == 8'h00;
    endproperty
    a_unlock_zero: assert property (p_unlock_zero)
        else $error("unlock port or unmapped offset read nonzero");
    property p_data_high_top;
        req.rd && req.addr == `NVAC_OFS_DATA_HIGH |=> rdata[7:6] == 2'b00;
    endproperty
    a_data_high_top: assert property (p_data_high_top)
        else $error("data high top bits not zero");
    property p_addr_high_top;
        req.rd && req.addr == `NVAC_OFS_ADDR_HIGH |=> rdata[7:4] == 4'h0;
    endproperty
    a_addr_high_top: assert property (p_addr_high_top)
        else $error("address high top bits not zero");
    property p_fetch_time;
        ctl_wr && req.wdata[7] && req.wdata[0] |-> ##2 prog_rd_reg;
    endproperty
    a_fetch_time: assert property (p_fetch_time)
        else $error("flash fetch not in second cycle after start");
    property p_skip_with_fetch;
        core_skip_reg == prog_rd_reg;
    endproperty
    a_skip_with_fetch: assert property (p_skip_with_fetch)
        else $error("core skip not aligned with fetch");
    property p_fetch_pulse;
        $rose(prog_rd_reg) |=> !prog_rd_reg [*2];
    endproperty
    a_fetch_pulse: assert property (p_fetch_pulse)
        else $error("flash strobe longer than one cycle");
    property p_data_no_fetch;
        ctl_wr && req.wdata[0] && !req.wdata[7] |=> !prog_rd_reg [*3];
    endproperty
    a_data_no_fetch: assert property (p_data_no_fetch)
        else $error("data read touched flash");
    property p_done_needs_unlock;
        write_done_flag |-> armed_reg;
    endproperty
    a_done_needs_unlock: assert property (p_done_needs_unlock)
        else $error("write completed without a legal start");
    property p_done_pulse;
        write_done_flag |=> !write_done_flag;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("completion pulse longer than one cycle");
endmodule

bind nvac_ctrl nvac_ctrl_checker #(
    .WRITE_CYCLES(WRITE_CYCLES),
    .PWRUP_CYCLES(PWRUP_CYCLES)
) u_nvac_ctrl_checker (
    .sys_clk(sys_clk), .srst(srst), .power_on_reset(power_on_reset),
    .external_master_reset(external_master_reset), .watchdog_timer(watchdog_timer),
    .brownout_reset(brownout_reset), .req(req), .rdata(rdata),
    .prog_rd_reg(prog_rd_reg), .prog_addr_reg(prog_addr_reg), .prog_word(prog_word),
    .core_skip_reg(core_skip_reg), .write_done_flag(write_done_flag)
);

// File: test/eeprom_flash_access_ctrl_tb.sv
// Self-checking testbench for the nonvolatile access controller.
`timescale 1ns/10ps
`include "nvac_consts.svh"
module eeprom_flash_access_ctrl_tb
    import nvac_pkg::*;
();
    // ************************************************************
    // Signals and instances
    // ************************************************************
    localparam int         WRITE_CYCLES = 20;
    localparam int         PWRUP_CYCLES = 60;
    localparam logic [2:0] DL = `NVAC_OFS_DATA_LOW, AL = `NVAC_OFS_ADDR_LOW;
    localparam logic [2:0] DH = `NVAC_OFS_DATA_HIGH, AH = `NVAC_OFS_ADDR_HIGH;
    localparam logic [2:0] CTL = `NVAC_OFS_CONTROL, UNL = `NVAC_OFS_UNLOCK;
    logic        sys_clk, srst, power_on_reset;
    logic        external_master_reset, watchdog_timer, brownout_reset;
    nvac_req_t   req;
    logic [7:0]  rdata;
    logic        prog_rd_reg, core_skip_reg, write_done_flag;
    logic [11:0] prog_addr_reg;
    logic [13:0] prog_word, word_exp;
    int          bad_count = 0, comparisons = 0, cycles = 0, done_count = 0, n;

    nvac_ctrl #(.WRITE_CYCLES(WRITE_CYCLES), .PWRUP_CYCLES(PWRUP_CYCLES)) u_nvac_ctrl (
        .sys_clk(sys_clk), .srst(srst), .power_on_reset(power_on_reset),
        .external_master_reset(external_master_reset), .watchdog_timer(watchdog_timer),
        .brownout_reset(brownout_reset), .req(req), .rdata(rdata),
        .prog_rd_reg(prog_rd_reg), .prog_addr_reg(prog_addr_reg), .prog_word(prog_word),
        .core_skip_reg(core_skip_reg), .write_done_flag(write_done_flag));
    nvac_flash_model u_nvac_flash_model (.sys_clk(sys_clk), .prog_rd_reg(prog_rd_reg),
        .prog_addr_reg(prog_addr_reg), .prog_word(prog_word));

    // 25 MHz clock.
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // Completion pulses are counted here; the cycle ceiling stops a hang.
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (write_done_flag === 1'b1) done_count <= done_count + 1;
        if (cycles == 3000) begin
            bad_count++;
            summarize();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One strobe cycle, then an idle cycle so no signal is driven twice at one edge.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        req <= '0;
    endtask
    task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        req <= '0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic start_write(input logic [7:0] ctl);
        wr(UNL, `NVAC_KEY_FIRST);
        wr(UNL, `NVAC_KEY_SECOND);
        wr(CTL, ctl);
    endtask
    task automatic do_reset(input logic por, input logic [2:0] cause, input int cnt);
        @(posedge sys_clk);
        srst <= 1'b1;
        power_on_reset <= por;
        {external_master_reset, watchdog_timer, brownout_reset} <= cause;
        repeat (cnt) @(posedge sys_clk);
        srst <= 1'b0;
        power_on_reset <= 1'b0;
        {external_master_reset, watchdog_timer, brownout_reset} <= 3'b000;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        req = '0;
        {srst, power_on_reset, external_master_reset, watchdog_timer, brownout_reset} = 5'h18;
        do_reset(1'b1, 3'b000, 20);
        for (int a = 0; a < 8; a++) begin
            rdchk(a[2:0], 8'h00);
        end
        // Still inside the power-up window, so the start must not take.
        wr(CTL, 8'h04);
        start_write(8'h06);
        rdchk(CTL, 8'h04);
        repeat (PWRUP_CYCLES) @(posedge sys_clk);
        $display("test reset and power-up done");
        wr(DH, 8'hFF);
        wr(AH, 8'hFF);
        rdchk(DH, 8'h3F);
        rdchk(AH, 8'h0F);
        wr(UNL, 8'h12);
        rdchk(UNL, 8'h00);
        wr(AH, 8'h05);
        wr(CTL, 8'h00);
        start_write(8'h06);
        rdchk(CTL, 8'h04);
        wr(CTL, 8'h04);
        wr(UNL, 8'hAA);
        wr(UNL, 8'h55);
        wr(CTL, 8'h06);
        rdchk(CTL, 8'h04);
        wr(UNL, 8'h55);
        rdchk(AL, 8'h00);
        wr(UNL, 8'hAA);
        wr(CTL, 8'h06);
        rdchk(CTL, 8'h04);
        wr(CTL, 8'h84);
        start_write(8'h86);
        rdchk(CTL, 8'h84);
        repeat (WRITE_CYCLES + 10) @(posedge sys_clk);
        check(done_count[15:0], 16'h0000);
        $display("test refused starts done");
        wr(AL, 8'h3C);
        wr(DL, 8'hA5);
        wr(CTL, 8'h04);
        start_write(8'h06);
        rdchk(CTL, 8'h06);
        wr(CTL, 8'h00);
        rdchk(CTL, 8'h02);
        n = 0;
        while (done_count == 0 && n < 100) begin
            @(posedge sys_clk);
            n++;
        end
        check(16'(n >= WRITE_CYCLES - 4 && n <= WRITE_CYCLES), 16'h0001);
        check(done_count[15:0], 16'h0001);
        rdchk(CTL, 8'h00);
        wr(DL, 8'h00);
        wr(CTL, 8'h01);
        rdchk(DL, 8'hA5);
        rdchk(CTL, 8'h00);
        rdchk(DL, 8'hA5);
        $display("test data write and read done");
        word_exp = {2'b10, 12'h59A ^ 12'h3C5};
        wr(AL, 8'h9A);
        wr(CTL, 8'h81);
        repeat (2) @(posedge sys_clk);
        rdchk(DL, word_exp[7:0]);
        rdchk(DH, {2'b00, word_exp[13:8]});
        rdchk(DL, word_exp[7:0]);
        rdchk(CTL, 8'h80);
        $display("test program read done");
        // Each non-power-on reset cause cuts a running write short.
        for (int i = 0; i < 3; i++) begin
            wr(CTL, 8'h04);
            start_write(8'h06);
            repeat (4) @(posedge sys_clk);
            do_reset(1'b0, 3'b100 >> i, 2);
            rdchk(CTL, 8'h08);
            wr(CTL, 8'h00);
        end
        repeat (WRITE_CYCLES + 10) @(posedge sys_clk);
        check(done_count[15:0], 16'h0001);
        $display("test write abort done");
        summarize();
    end
endmodule
